// File: src/mpg_cfg_top.sv
/*
 mpg_cfg_top: margin-low step, threshold select, on/off delay and option
 commands with reference slewing, power-good supervision and telemetry hold.
 assumes feedback, trim and telemetry inputs come from mclk logic; the enable
 pin is asynchronous; commands arrive on link_clk.
*/
`timescale 1ns/1ps
`include "mpg_regs.svh"

module mpg_cfg_top
   import mpg_pkg::*;
#(
   parameter logic [11:0] HYST_PERMILLE = 12'd20
) (
   // clocks and reset
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        link_clk,
   // command link, link_clk
   input  wire logic        cmd_valid,
   input  wire mpg_cmd_t    cmd,
   output logic             cmd_ready,
   output logic             rsp_valid,
   output logic [15:0]      rsp_data,
   // operating controls, mclk except output_enable_pin, which is asynchronous
   input  wire logic        output_enable_pin,
   input  wire logic        margin_low_sel,
   input  wire logic        clear_faults,
   input  wire logic [15:0] reference_trim,
   input  wire logic [23:0] ton_rise_cycles,
   input  wire logic [15:0] soft_start_step_cycles,
   input  wire logic [11:0] feedback_input,
   input  wire mpg_telem_t  telem_in,
   // reference and sequencing
   output logic [9:0]       reference_code,
   output logic             switching,
   output logic             soft_start_active,
   // supervision
   output logic             power_good,
   output logic             ov_fault,
   output logic             uv_fault,
   output logic             smbalert,
   output logic             status_byte_cml,
   output logic             status_cml_invalid_data,
   // telemetry and non-volatile store
   output mpg_telem_t       telem_out,
   output logic             nvm_store,
   output mpg_nvm_t         nvm_data
);

   localparam logic signed [17:0] ML_MIN  = 18'(`MPG_ML_MIN_MV / `MPG_LSB_MV);
   localparam logic signed [17:0] ML_MAX  = 18'(`MPG_ML_MAX_MV / `MPG_LSB_MV);
   localparam logic signed [17:0] ADJ_MIN = 18'(`MPG_ADJ_MIN_MV / `MPG_LSB_MV);
   localparam logic signed [17:0] ADJ_MAX = 18'(`MPG_ADJ_MAX_MV / `MPG_LSB_MV);
   localparam logic signed [17:0] NOM     = 18'(`MPG_NOM_MV / `MPG_LSB_MV);
   localparam logic [26:0] MIN_ON_CYC     = 27'(`MPG_MIN_ON_DELAY_CYC);
   localparam logic [15:0] SLOW_STEP_CYC  = 16'(`MPG_SLOW_STEP_CYC);

   // crossing
   logic             req_toggle;
   mpg_cmd_t         req_hold;
   logic             req_s;
   logic             req_prev_q;
   logic             req_evt;
   logic             ack_toggle_q;
   logic [15:0]      ack_data_q;
   logic             en_s;
   logic             en_prev_q;

   // registers
   logic [15:0]      margin_low_q;
   logic [7:0]       thresh_sel_q;
   logic [7:0]       delay_cfg_q;
   logic [15:0]      options_q;

   // reference path
   logic signed [17:0] wr_val;
   logic               wr_ml;
   logic               ml_low;
   logic               ml_high;
   logic signed [17:0] adj_raw;
   logic signed [17:0] adj;
   logic               adj_err;
   logic [9:0]         target;
   logic [15:0]        slew_cnt_q;
   logic [15:0]        slew_int;
   mpg_seq_t           state_q;
   logic [26:0]        delay_cnt_q;
   logic [26:0]        ton_cycles;
   logic [26:0]        toff_cycles;
   logic               pg_fault_q;
   logic [47:0]        thr;
   logic [11:0]        uv_th;
   logic [11:0]        pgl_th;
   logic [11:0]        pgh_th;
   logic [11:0]        ov_th;
   logic               err_set;

   function automatic logic [47:0] thr_table(input logic [1:0] code);
      case (code)
         2'b00:   thr_table = `MPG_THR_CODE0;
         2'b01:   thr_table = `MPG_THR_CODE1;
         2'b10:   thr_table = `MPG_THR_CODE2;
         default: thr_table = `MPG_THR_CODE3;
      endcase
   endfunction : thr_table

   function automatic logic [15:0] reg_read(input logic [7:0] code,
                                            input logic [15:0] ml,
                                            input logic [7:0] ts,
                                            input logic [7:0] dc,
                                            input logic [15:0] op);
      case (code)
         `MPG_OFS_MARGIN_LOW: reg_read = ml;
         `MPG_OFS_THRESH_SEL: reg_read = {8'h00, ts};
         `MPG_OFS_DELAY_CFG:  reg_read = {8'h00, dc};
         `MPG_OFS_OPTIONS:    reg_read = op;
         default:             reg_read = 16'h0000;
      endcase
   endfunction : reg_read

   mpg_link_port u_link (
      .link_clk   (link_clk),
      .sys_rst    (sys_rst),
      .cmd_valid  (cmd_valid),
      .cmd        (cmd),
      .cmd_ready  (cmd_ready),
      .rsp_valid  (rsp_valid),
      .rsp_data   (rsp_data),
      .req_toggle (req_toggle),
      .req_hold   (req_hold),
      .ack_toggle (ack_toggle_q),
      .ack_data   (ack_data_q)
   );

   mpg_sync #(.WIDTH(2)) u_sync (
      .clk (mclk),
      .rst (sys_rst),
      .d   ({req_toggle, output_enable_pin}),
      .q   ({req_s, en_s})
   );

   assign req_evt = req_s ^ req_prev_q;

   // write decode and step range check
   assign wr_val  = 18'(signed'(req_hold.wdata));
   assign wr_ml   = req_evt && req_hold.write && (req_hold.code == `MPG_OFS_MARGIN_LOW);
   assign ml_low  = wr_val < ML_MIN;
   assign ml_high = wr_val > ML_MAX;

   // combined adjustment
   always_comb begin
      adj_raw = 18'(signed'(reference_trim));
      if (margin_low_sel) begin
         adj_raw = 18'(signed'(margin_low_q)) + 18'(signed'(reference_trim));
      end
      adj     = adj_raw;
      adj_err = 1'b0;
      if (adj_raw < ADJ_MIN) begin
         adj     = ADJ_MIN;
         adj_err = 1'b1;
      end else if (adj_raw > ADJ_MAX) begin
         adj     = ADJ_MAX;
         adj_err = 1'b1;
      end
   end

   assign target  = 10'(NOM + adj);
   assign err_set = adj_err || (wr_ml && (ml_low || ml_high));

   // command handling and answers
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         req_prev_q   <= 1'b0;
         ack_toggle_q <= 1'b0;
         ack_data_q   <= '0;
      end else begin
         req_prev_q <= req_s;
         if (req_evt) begin
            ack_data_q   <= reg_read(req_hold.code, margin_low_q, thresh_sel_q,
                                     delay_cfg_q, options_q);
            ack_toggle_q <= ~ack_toggle_q;
         end
      end
   end

   // margin low step
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         margin_low_q <= `MPG_RST_MARGIN_LOW;
      end else if (wr_ml) begin
         if (ml_low) begin
            margin_low_q <= 16'(ML_MIN);
         end else if (ml_high) begin
            margin_low_q <= 16'(ML_MAX);
         end else begin
            margin_low_q <= req_hold.wdata;
         end
      end
   end

   // other configuration registers
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         thresh_sel_q <= `MPG_RST_THRESH_SEL;
         delay_cfg_q  <= `MPG_RST_DELAY_CFG;
         options_q    <= `MPG_RST_OPTIONS;
      end else if (req_evt && req_hold.write) begin
         case (req_hold.code)
            `MPG_OFS_THRESH_SEL: begin
               thresh_sel_q <= {6'h00, req_hold.wdata[`MPG_THR_W-1:0]};
            end
            `MPG_OFS_DELAY_CFG: begin
               delay_cfg_q <= {req_hold.wdata[`MPG_TON_POS+:`MPG_DLY_W], 1'b0,
                               req_hold.wdata[`MPG_TOFF_POS+:`MPG_DLY_W], 1'b0};
            end
            `MPG_OFS_OPTIONS: begin
               options_q <= `MPG_OPT_FIXED |
                            (16'(req_hold.wdata[`MPG_OPT_TELEM_BIT]) << `MPG_OPT_TELEM_BIT);
            end
            default: begin
            end
         endcase
      end
   end

   // command error flags, set wins over clear
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         status_byte_cml         <= 1'b0;
         status_cml_invalid_data <= 1'b0;
         smbalert                <= 1'b0;
      end else begin
         status_byte_cml         <= err_set || (status_byte_cml && !clear_faults);
         status_cml_invalid_data <= err_set ||
                                    (status_cml_invalid_data && !clear_faults);
         smbalert                <= err_set || (smbalert && !clear_faults);
      end
   end

   // sequencing
   assign ton_cycles  = 27'(delay_cfg_q[`MPG_TON_POS+:`MPG_DLY_W]) * 27'(ton_rise_cycles);
   assign toff_cycles = 27'(delay_cfg_q[`MPG_TOFF_POS+:`MPG_DLY_W]) * 27'(ton_rise_cycles);

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q     <= SEQ_OFF;
         delay_cnt_q <= '0;
         en_prev_q   <= 1'b0;
      end else begin
         en_prev_q <= en_s;
         case (state_q)
            SEQ_OFF: begin
               if (en_s && !en_prev_q) begin
                  state_q     <= SEQ_ON_DELAY;
                  delay_cnt_q <= (ton_cycles == 27'd0) ? MIN_ON_CYC : ton_cycles;
               end
            end
            SEQ_ON_DELAY: begin
               if (!en_s) begin
                  state_q <= SEQ_OFF;
               end else if (delay_cnt_q <= 27'd1) begin
                  state_q <= SEQ_SOFTSTART;
               end else begin
                  delay_cnt_q <= delay_cnt_q - 27'd1;
               end
            end
            SEQ_SOFTSTART, SEQ_ON: begin
               if (!en_s) begin
                  state_q     <= SEQ_OFF_DELAY;
                  delay_cnt_q <= toff_cycles;
               end else if (state_q == SEQ_SOFTSTART && reference_code == target) begin
                  state_q <= SEQ_ON;
               end
            end
            SEQ_OFF_DELAY: begin
               if (delay_cnt_q <= 27'd1) begin
                  state_q <= SEQ_OFF;
               end else begin
                  delay_cnt_q <= delay_cnt_q - 27'd1;
               end
            end
            default: begin
               state_q <= SEQ_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         switching         <= 1'b0;
         soft_start_active <= 1'b0;
      end else begin
         switching         <= (state_q == SEQ_SOFTSTART) || (state_q == SEQ_ON) ||
                              (state_q == SEQ_OFF_DELAY);
         soft_start_active <= (state_q == SEQ_SOFTSTART);
      end
   end

   // reference slewing, one 2 mV step per interval
   assign slew_int = (state_q == SEQ_SOFTSTART) ? soft_start_step_cycles
                                                : SLOW_STEP_CYC;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         reference_code <= '0;
         slew_cnt_q     <= '0;
      end else if (state_q == SEQ_OFF || state_q == SEQ_ON_DELAY) begin
         reference_code <= '0;
         slew_cnt_q     <= '0;
      end else if (reference_code == target) begin
         slew_cnt_q <= '0;
      end else if (slew_cnt_q + 16'd1 >= slew_int) begin
         slew_cnt_q <= '0;
         if (reference_code < target) begin
            reference_code <= reference_code + 10'd1;
         end else begin
            reference_code <= reference_code - 10'd1;
         end
      end else begin
         slew_cnt_q <= slew_cnt_q + 16'd1;
      end
   end

   // supervision thresholds
   assign thr    = thr_table(thresh_sel_q[`MPG_THR_W-1:0]);
   assign uv_th  = thr[47:36];
   assign pgl_th = thr[35:24];
   assign pgh_th = thr[23:12];
   assign ov_th  = thr[11:0];

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pg_fault_q <= 1'b1;
         ov_fault   <= 1'b0;
         uv_fault   <= 1'b0;
      end else begin
         if (feedback_input > pgh_th || feedback_input < pgl_th) begin
            pg_fault_q <= 1'b1;
         end else if (feedback_input < pgh_th - HYST_PERMILLE &&
                      feedback_input > pgl_th + HYST_PERMILLE) begin
            pg_fault_q <= 1'b0;
         end
         if (feedback_input > ov_th) begin
            ov_fault <= 1'b1;
         end else if (feedback_input < pgh_th - HYST_PERMILLE) begin
            ov_fault <= 1'b0;
         end
         if (feedback_input < uv_th) begin
            uv_fault <= 1'b1;
         end else if (feedback_input > pgl_th + HYST_PERMILLE) begin
            uv_fault <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         power_good <= 1'b0;
      end else begin
         power_good <= !pg_fault_q && !ov_fault && !uv_fault &&
                       (state_q == SEQ_ON);
      end
   end

   // telemetry hold
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         telem_out <= '0;
      end else if (options_q[`MPG_OPT_TELEM_BIT]) begin
         telem_out <= telem_in;
      end
   end

   // non-volatile store
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         nvm_store <= 1'b0;
         nvm_data  <= '0;
      end else begin
         nvm_store <= req_evt && req_hold.write && (req_hold.code == `MPG_CMD_STORE_ALL);
         if (req_evt && req_hold.write && (req_hold.code == `MPG_CMD_STORE_ALL)) begin
            nvm_data <= '{margin_low_step: margin_low_q, user_options: options_q};
         end
      end
   end

endmodule : mpg_cfg_top

// File: src/mpg_regs.svh
/*
 mpg_regs.svh: command codes, reset values, field positions and timing counts
 of the margin, power-good and sequencing configuration block.
 assumes a 40 MHz mclk; included by bare name after the package.
*/
`ifndef MPG_REGS_SVH
`define MPG_REGS_SVH

// command codes
`define MPG_OFS_MARGIN_LOW    8'hd6
`define MPG_OFS_THRESH_SEL    8'hd7
`define MPG_OFS_DELAY_CFG     8'hd8
`define MPG_OFS_OPTIONS       8'he5
`define MPG_CMD_STORE_ALL     8'h15

// reset and fixed values
`define MPG_RST_MARGIN_LOW    16'hffe2
`define MPG_RST_THRESH_SEL    8'h00
`define MPG_RST_DELAY_CFG     8'h00
`define MPG_RST_OPTIONS       16'h0074
`define MPG_OPT_FIXED         16'h0070

// field positions
`define MPG_OPT_TELEM_BIT     2
`define MPG_THR_W             2
`define MPG_DLY_W             3
`define MPG_TON_POS           5
`define MPG_TOFF_POS          1

// voltage figures in mV, reference in 2 mV steps
`define MPG_LSB_MV            2
`define MPG_NOM_MV            600
`define MPG_ML_MIN_MV         (-120)
`define MPG_ML_MAX_MV         0
`define MPG_ADJ_MIN_MV        (-180)
`define MPG_ADJ_MAX_MV        60

// thresholds in per-mille of nominal: uv, good low, good high, ov
`define MPG_THR_CODE0         {12'd832, 12'd875, 12'd1125, 12'd1168}
`define MPG_THR_CODE1         {12'd880, 12'd930, 12'd1070, 12'd1120}
`define MPG_THR_CODE2         {12'd720, 12'd780, 12'd1070, 12'd1120}
`define MPG_THR_CODE3         {12'd580, 12'd640, 12'd1070, 12'd1120}

// timing
`define MPG_MCLK_NS           25
`define MPG_MIN_ON_DELAY_US   50
`define MPG_MIN_ON_DELAY_CYC  ((`MPG_MIN_ON_DELAY_US * 1000 + `MPG_MCLK_NS - 1) / `MPG_MCLK_NS)
`define MPG_SLOW_RATE_UV_US   67
`define MPG_SLOW_STEP_CYC     ((`MPG_LSB_MV * 1000 * 1000) / (`MPG_SLOW_RATE_UV_US * `MPG_MCLK_NS))

`endif

// File: src/mpg_pkg.sv
/*
 mpg_pkg: types shared by the configuration block and its link port.
 assumes nothing beyond a SystemVerilog compiler.
*/
package mpg_pkg;

   typedef struct packed {
      logic        write;
      logic [7:0]  code;
      logic [15:0] wdata;
   } mpg_cmd_t;

   typedef struct packed {
      logic [15:0] vout;
      logic [15:0] iout;
      logic [15:0] temp;
   } mpg_telem_t;

   typedef struct packed {
      logic [15:0] margin_low_step;
      logic [15:0] user_options;
   } mpg_nvm_t;

   typedef enum logic [4:0] {
      SEQ_OFF       = 5'b00001,
      SEQ_ON_DELAY  = 5'b00010,
      SEQ_SOFTSTART = 5'b00100,
      SEQ_ON        = 5'b01000,
      SEQ_OFF_DELAY = 5'b10000
   } mpg_seq_t;

endpackage : mpg_pkg

// File: src/mpg_sync.sv
/*
 mpg_sync: two-flop level synchroniser.
 assumes each bit changes independently or is held stable by a handshake.
*/
`timescale 1ns/1ps
module mpg_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // level in and out
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule : mpg_sync

// File: src/mpg_link_port.sv
/*
 mpg_link_port: link-clock end of the command path; holds one command,
 toggles a request to the mclk side and returns its answer.
 assumes ack_data is stable whenever ack_toggle changes.
*/
`timescale 1ns/1ps
module mpg_link_port
   import mpg_pkg::*;
(
   // clock and reset
   input  wire logic        link_clk,
   input  wire logic        sys_rst,
   // host side
   input  wire logic        cmd_valid,
   input  wire mpg_cmd_t    cmd,
   output logic             cmd_ready,
   output logic             rsp_valid,
   output logic [15:0]      rsp_data,
   // crossing
   output logic             req_toggle,
   output mpg_cmd_t         req_hold,
   input  wire logic        ack_toggle,
   input  wire logic [15:0] ack_data
);

   logic ack_s;
   logic ack_prev_q;
   logic ack_evt;

   mpg_sync #(.WIDTH(1)) u_ack_sync (
      .clk (link_clk),
      .rst (sys_rst),
      .d   (ack_toggle),
      .q   (ack_s)
   );

   assign ack_evt = ack_s ^ ack_prev_q;

   // accept one command, hold it until answered
   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmd_ready  <= 1'b1;
         req_toggle <= 1'b0;
         req_hold   <= '0;
      end else if (cmd_valid && cmd_ready) begin
         cmd_ready  <= 1'b0;
         req_toggle <= ~req_toggle;
         req_hold   <= cmd;
      end else if (ack_evt) begin
         cmd_ready  <= 1'b1;
      end
   end

   // answer
   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_prev_q <= 1'b0;
         rsp_valid  <= 1'b0;
         rsp_data   <= '0;
      end else begin
         ack_prev_q <= ack_s;
         rsp_valid  <= ack_evt;
         if (ack_evt) begin
            rsp_data <= ack_data;
         end
      end
   end

endmodule : mpg_link_port

// File: dv/mpg_cfg_props.sv
/*
 mpg_cfg_props: port timing checks of the configuration block.
 assumes it is bound into mpg_cfg_top.
*/
`timescale 1ns/1ps
module mpg_cfg_props (
   // clocks and reset
   input logic        mclk,
   input logic        link_clk,
   input logic        sys_rst,
   // watched ports
   input logic        rsp_valid,
   input logic        output_enable_pin,
   input logic [15:0] soft_start_step_cycles,
   input logic [9:0]  reference_code,
   input logic        switching,
   input logic        soft_start_active,
   input logic        power_good,
   input logic        ov_fault,
   input logic        uv_fault,
   input logic        status_byte_cml,
   input logic        status_cml_invalid_data,
   input logic        nvm_store
);
   logic [9:0]  ref_q;
   logic [11:0] stab_q;
   logic [11:0] en_q;
   logic        chg;
   assign chg = reference_code != ref_q;
   // cycles since the reference last moved
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ref_q  <= '0;
         stab_q <= '0;
      end else begin
         ref_q  <= reference_code;
         stab_q <= chg ? '0 : stab_q + {11'h0, stab_q != 12'hfff};
      end
   end
   // cycles with enable high
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) en_q <= '0;
      else if (!output_enable_pin) en_q <= '0;
      else if (en_q != 12'hfff) en_q <= en_q + 12'd1;
   end
   a_rsp_one: assert property (@(posedge link_clk) disable iff (sys_rst)
      rsp_valid |=> !rsp_valid) else $error("answer pulse too long");
   a_ov_pg: assert property (@(posedge mclk) disable iff (sys_rst)
      ov_fault |=> !power_good) else $error("good with overvoltage");
   a_uv_pg: assert property (@(posedge mclk) disable iff (sys_rst)
      uv_fault |=> !power_good) else $error("good with undervoltage");
   a_on_min: assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(soft_start_active) |-> en_q >= 12'd2000) else $error("on delay short");
   a_ss_rate: assert property (@(posedge mclk) disable iff (sys_rst)
      soft_start_active && $past(soft_start_active) && chg
      |-> {4'h0, stab_q} + 16'd1 >= soft_start_step_cycles) else $error("ramp fast");
   a_slew_rate: assert property (@(posedge mclk) disable iff (sys_rst)
      switching && $past(switching) && !soft_start_active && !$past(soft_start_active)
      && chg |-> stab_q >= 12'd1193) else $error("slew fast");
   a_nvm_one: assert property (@(posedge mclk) disable iff (sys_rst)
      nvm_store |=> !nvm_store) else $error("store pulse long");
   a_flag_pair: assert property (@(posedge mclk) disable iff (sys_rst)
      status_byte_cml == status_cml_invalid_data) else $error("flags differ");
   c_ss: cover property (@(posedge mclk) $rose(soft_start_active));
   c_ov: cover property (@(posedge mclk) $rose(ov_fault));
   c_nvm: cover property (@(posedge mclk) nvm_store);
endmodule : mpg_cfg_props

bind mpg_cfg_top mpg_cfg_props u_mpg_cfg_props (
   .mclk, .link_clk, .sys_rst, .rsp_valid, .output_enable_pin, .soft_start_step_cycles,
   .reference_code, .switching, .soft_start_active, .power_good, .ov_fault, .uv_fault,
   .status_byte_cml, .status_cml_invalid_data, .nvm_store
);

// File: dv/mpg_host_model.sv
/*
 mpg_host_model: command host on the link clock, one command at a time.
 assumes a free running link_clk.
*/
`timescale 1ns/1ps
module mpg_host_model
   import mpg_pkg::*;
(
   // link side
   input  wire logic link_clk,
   output logic      cmd_valid,
   output mpg_cmd_t  cmd,
   input  wire logic cmd_ready,
   input  wire logic rsp_valid
);
   initial begin
      cmd_valid = 1'b0;
      cmd       = '0;
   end
   // hold until taken, scramble when released, wait for the answer
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge link_clk);
      cmd_valid <= 1'b1;
      cmd       <= {w, c, d};
      do @(posedge link_clk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      cmd       <= ~cmd;
      while (rsp_valid !== 1'b1 && n < 40) begin
         @(posedge link_clk);
         n++;
      end
   endtask : xfer
endmodule : mpg_host_model

// File: dv/tb.sv
/*
 tb: register, supervision, sequencing and telemetry tests.
 assumes the design, host model and checker are compiled before it.
*/
`timescale 1ns/1ps
module tb
   import mpg_pkg::*;
;
   logic        mclk = 1'b0, link_clk = 1'b0, sys_rst = 1'b1;
   logic        cmd_valid, cmd_ready, rsp_valid, switching, soft_start_active;
   logic        power_good, ov_fault, uv_fault, smbalert, status_byte_cml;
   logic        status_cml_invalid_data, nvm_store;
   mpg_cmd_t    cmd;
   logic [15:0] rsp_data, r;
   logic        output_enable_pin = 1'b0, margin_low_sel = 1'b0, clear_faults = 1'b0;
   logic [15:0] reference_trim = 16'h0, soft_start_step_cycles = 16'h2;
   logic [23:0] ton_rise_cycles = 24'd2500;
   logic [11:0] feedback_input = 12'd1000;
   mpg_telem_t  telem_in = '0, telem_out, t0, t1;
   logic [9:0]  reference_code;
   mpg_nvm_t    nvm_data;
   logic [15:0] exp_q[$];
   logic [11:0] good_lower_threshold[4] = '{12'd875, 12'd930, 12'd780, 12'd640};
   logic [11:0] fbv[7] = '{12'd1000, 12'd1200, 12'd1110, 12'd1100, 12'd700, 12'd880, 12'd950};
   logic [2:0]  fex[7] = '{3'h1, 3'h4, 3'h4, 3'h1, 3'h2, 3'h2, 3'h1};
   int          err_count = 0, n_checks = 0, n, n_store = 0;
   always #12.5 mclk = ~mclk;
   initial begin
      #3;
      forever #7.5 link_clk = ~link_clk;
   end
   mpg_cfg_top u_mpg_cfg_top (
      .mclk, .sys_rst, .link_clk, .cmd_valid, .cmd, .cmd_ready, .rsp_valid, .rsp_data,
      .output_enable_pin, .margin_low_sel, .clear_faults, .reference_trim, .ton_rise_cycles,
      .soft_start_step_cycles, .feedback_input, .telem_in, .reference_code, .switching,
      .soft_start_active, .power_good, .ov_fault, .uv_fault, .smbalert, .status_byte_cml,
      .status_cml_invalid_data, .telem_out, .nvm_store, .nvm_data
   );
   mpg_host_model u_mpg_host_model (.link_clk, .cmd_valid, .cmd, .cmd_ready, .rsp_valid);
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test();
      if (err_count == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : stop_test
   task automatic op(input logic w, input logic [7:0] a, input logic [15:0] d, e);
      exp_q.push_back(e);
      u_mpg_host_model.xfer(w, a, d);
   endtask : op
   task automatic wm(input int k);
      repeat (k) @(posedge mclk);
   endtask : wm
   // answers against oldest note, an answer with no note is a mismatch
   always @(posedge link_clk) begin
      if (rsp_valid === 1'b1) begin
         if (exp_q.size() == 0) check(1'b1, 1'b0);
         else check(rsp_data, exp_q.pop_front());
      end
   end
   // store pulses seen
   always @(posedge mclk) if (nvm_store === 1'b1) n_store++;
   initial begin
      #2_000_000;
      err_count++;
      stop_test();
   end
   initial begin
      void'($urandom(7));
      t0 = 48'({$urandom, $urandom});
      t1 = 48'({$urandom, $urandom});
      telem_in = t0;
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge link_clk);
      op(0, 8'hd6, 16'h0, 16'hffe2);
      op(0, 8'hd7, 16'h0, 16'h0);
      op(0, 8'hd8, 16'h0, 16'h0);
      op(0, 8'he5, 16'h0, 16'h0074);
      op(0, 8'hd0, 16'h0, 16'h0);
      op(1, 8'hd7, 16'hffff, 16'h0);
      op(1, 8'hd8, 16'hffff, 16'h0);
      op(1, 8'hd8, 16'h0024, 16'h00ee);
      r = 16'(-$urandom_range(60, 0));
      op(1, 8'hd6, r, 16'hffe2);
      op(1, 8'hd6, 16'hffc3, r);
      check({smbalert, status_byte_cml, status_cml_invalid_data}, 3'h7);
      op(1, 8'hd6, 16'h0005, 16'hffc4);
      op(1, 8'hd6, 16'hffe2, 16'h0);
      @(posedge mclk) clear_faults <= 1'b1;
      @(posedge mclk) clear_faults <= 1'b0;
      wm(2);
      check({smbalert, status_byte_cml, status_cml_invalid_data}, 3'h0);
      op(1, 8'he5, 16'h0, 16'h0074);
      @(posedge mclk) telem_in <= t1;
      wm(4);
      check(telem_out, t0);
      op(1, 8'he5, 16'hffff, 16'h0070);
      op(0, 8'he5, 16'h0, 16'h0074);
      wm(4);
      check(telem_out, t1);
      op(1, 8'h15, 16'h0, 16'h0);
      check(nvm_data, {16'hffe2, 16'h0074});
      @(posedge mclk) output_enable_pin <= 1'b1;
      for (n = 0; soft_start_active !== 1'b1 && n < 9000; n++) @(negedge mclk);
      check(n >= 2500 && n <= 2508, 1'b1);
      for (n = 0; soft_start_active !== 1'b0 && n < 2000; n++) @(negedge mclk);
      check(reference_code, 10'd300);
      for (int k = 0; k < 4; k++) begin
         op(1, 8'hd7, 16'(k), 16'((k + 3) % 4));
         @(posedge mclk) feedback_input <= good_lower_threshold[k] - 12'd5;
         wm(4);
         check(power_good, 1'b0);
         @(posedge mclk) feedback_input <= good_lower_threshold[k] + 12'd25;
         wm(4);
         check(power_good, 1'b1);
      end
      @(posedge mclk) feedback_input <= 12'd1000;
      op(1, 8'hd7, 16'h0, 16'h3);
      for (int i = 0; i < 7; i++) begin
         @(posedge mclk) feedback_input <= fbv[i];
         wm(4);
         check({ov_fault, uv_fault, power_good}, fex[i]);
      end
      @(posedge mclk) begin
         reference_trim <= 16'hfff6;
         margin_low_sel <= 1'b1;
      end
      for (n = 0; reference_code !== 10'd260 && n < 60000; n++) @(negedge mclk);
      check(reference_code, 10'd260);
      check(n >= 39 * 1194, 1'b1);
      @(posedge mclk) reference_trim <= 16'hffb0;
      wm(4);
      check({smbalert, status_byte_cml, status_cml_invalid_data}, 3'h7);
      @(posedge mclk) output_enable_pin <= 1'b0;
      for (n = 0; switching !== 1'b0 && n < 9000; n++) @(negedge mclk);
      check(n >= 5000 && n <= 5008, 1'b1);
      op(1, 8'hd8, 16'h0, 16'h0024);
      @(posedge mclk) output_enable_pin <= 1'b1;
      for (n = 0; soft_start_active !== 1'b1 && n < 9000; n++) @(negedge mclk);
      check(n >= 2000 && n <= 2008, 1'b1);
      check(exp_q.size(), 0);
      check(n_store, 1);
      stop_test();
   end
endmodule : tb
